// ==== design/msp_uart.sv ====
// serial slave port: character engine, frame detection, apb registers
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_uart #(
   parameter int CLK_HZ = `MSP_CLK_HZ,
   parameter int MS_CYC = `MSP_CLK_HZ / `MSP_MS_PER_S
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial line
   input  wire logic        rxd,
   output logic             txd,
   input  wire logic        cts,
   output logic             rts,
   output logic             line_rs485,
   output logic             drive_en
);
   logic [8:0]  ctrl_r;
   logic [13:0] gap_r;
   logic [6:0]  hsd_r;
   logic [7:0]  addr_r;
   logic [8:0]  st_r;
   logic [31:0] rd_r;
   logic        rxd_m_r, rxd_s_r, cts_m_r, cts_s_r;
   logic [31:0] ms_cnt_r;
   logic        ms_tick;
   logic [31:0] div;
   logic        text, flow, modem, hs_on;
   logic [2:0]  last_bit;
   msp_pkg::msp_par_e par;

   function automatic logic [31:0] baud_div(input logic [2:0] s, input int hz);
      logic [31:0] d;
      d = 32'(hz / 9600);
      unique case (s)
         3'(msp_pkg::BAUD_300):   d = 32'(hz / 300);
         3'(msp_pkg::BAUD_600):   d = 32'(hz / 600);
         3'(msp_pkg::BAUD_1200):  d = 32'(hz / 1200);
         3'(msp_pkg::BAUD_2400):  d = 32'(hz / 2400);
         3'(msp_pkg::BAUD_4800):  d = 32'(hz / 4800);
         3'(msp_pkg::BAUD_19200): d = 32'(hz / 19200);
         default:                 d = 32'(hz / 9600);
      endcase
      return d;
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
         x = x[0] ? ((x >> 1) ^ `MSP_CRC_POLY) : (x >> 1);
      return x;
   endfunction

   // returns {valid, nibble} for an ascii hex digit 0-9 or A-F (lowercase is not valid)
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      logic [4:0] v;
      v = 5'h00;
      if (c >= 8'h30 && c <= 8'h39)
         v = {1'b1, 4'(c - 8'h30)};
      else if (c >= 8'h41 && c <= 8'h46)
         v = {1'b1, 4'(c - 8'h37)};
      return v;
   endfunction

   function automatic logic par_bit(input logic [7:0] d, input logic t,
                                    input msp_pkg::msp_par_e p);
      logic x;
      x = t ? ^d[6:0] : ^d;
      return (p == msp_pkg::PAR_ODD) ? ~x : x;
   endfunction

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] s);
      return a == s || a == `MSP_ADDR_BCAST || s == `MSP_ADDR_P2P;
   endfunction

   assign div   = baud_div(ctrl_r[`MSP_CTRL_BAUD], CLK_HZ);
   assign text  = ctrl_r[`MSP_CTRL_TEXT];
   assign last_bit = text ? `MSP_BITS_TEXT : `MSP_BITS_BIN;
   assign par   = msp_pkg::msp_par_e'(ctrl_r[`MSP_CTRL_PAR]);
   assign hs_on = !ctrl_r[`MSP_CTRL_RS485] && ctrl_r[`MSP_CTRL_HS];
   assign flow  = hs_on && hsd_r == `MSP_HSD_RST;
   assign modem = hs_on && hsd_r != `MSP_HSD_RST;
   assign line_rs485 = ctrl_r[`MSP_CTRL_RS485];

   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rxd_m_r <= 1'b1;
         rxd_s_r <= 1'b1;
         cts_m_r <= 1'b0;
         cts_s_r <= 1'b0;
      end
      else
      begin
         rxd_m_r <= rxd;
         rxd_s_r <= rxd_m_r;
         cts_m_r <= cts;
         cts_s_r <= cts_m_r;
      end

   // free-running millisecond tick
   assign ms_tick = ms_cnt_r == 32'(MS_CYC - 1);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ms_cnt_r <= '0;
      else
         ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 32'h1;

   // ---------------- receiver
   msp_pkg::msp_rx_e rx_st_r;
   logic [31:0] rx_cnt_r;
   logic [2:0]  rx_bit_r;
   logic [7:0]  rx_sh_r;
   logic        rx_pbad_r, rx_v, rx_bad;
   logic [7:0]  rx_byte;
   assign rx_byte = text ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;

   // start, lsb first, parity, stop sampling
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rx_st_r   <= msp_pkg::RX_IDLE;
         rx_cnt_r  <= '0;
         rx_bit_r  <= '0;
         rx_sh_r   <= '0;
         rx_pbad_r <= 1'b0;
      end
      else
      begin
         rx_cnt_r <= (rx_cnt_r == '0) ? div - 32'h1 : rx_cnt_r - 32'h1;
         unique case (rx_st_r)
            msp_pkg::RX_IDLE:
               if (!rxd_s_r)
               begin
                  rx_st_r  <= msp_pkg::RX_START;
                  rx_cnt_r <= div >> 1;
               end
            msp_pkg::RX_START:
               if (rx_cnt_r == '0)
               begin
                  rx_st_r   <= rxd_s_r ? msp_pkg::RX_IDLE : msp_pkg::RX_DATA;
                  rx_bit_r  <= '0;
                  rx_pbad_r <= 1'b0;
               end
            msp_pkg::RX_DATA:
               if (rx_cnt_r == '0)
               begin
                  rx_sh_r  <= {rxd_s_r, rx_sh_r[7:1]};
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == last_bit)
                     rx_st_r <= (par == msp_pkg::PAR_NONE) ?
                                msp_pkg::RX_STOP : msp_pkg::RX_PAR;
               end
            msp_pkg::RX_PAR:
               if (rx_cnt_r == '0)
               begin
                  rx_pbad_r <= rxd_s_r != par_bit(rx_byte, text, par);
                  rx_st_r   <= msp_pkg::RX_STOP;
               end
            msp_pkg::RX_STOP:
               if (rx_cnt_r == '0)
                  rx_st_r <= msp_pkg::RX_IDLE;
         endcase
      end
   assign rx_v   = rx_st_r == msp_pkg::RX_STOP && rx_cnt_r == '0;
   assign rx_bad = rx_pbad_r || !rxd_s_r;

   // ---------------- frame detection
   logic        in_fr_r, first_r, nib_r, cr_r, fbad_r, hit_r;
   logic [15:0] crc_r;
   logic [7:0]  lrc_r;
   logic [3:0]  hi_r;
   logic [6:0]  sil_r;
   logic [13:0] gms_r;
   logic        fr_end, fr_err;
   logic [4:0]  hv;
   logic [7:0]  hbyte;
   logic [31:0] hb_cnt_r;
   logic        hb_tick;
   assign hv      = hex_val(rx_byte);
   assign hbyte   = {hi_r, hv[3:0]};
   assign hb_tick = hb_cnt_r == '0;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         hb_cnt_r <= '0;
      else if (rx_st_r != msp_pkg::RX_IDLE || hb_tick)
         hb_cnt_r <= (div >> 1) - 32'h1;
      else
         hb_cnt_r <= hb_cnt_r - 32'h1;

   // silence of 3.5 characters then the gap
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sil_r <= '0;
         gms_r <= '0;
      end
      else if (rx_st_r != msp_pkg::RX_IDLE || !in_fr_r || text)
      begin
         sil_r <= '0;
         gms_r <= '0;
      end
      else if (sil_r != `MSP_SIL_HALFBITS)
         sil_r <= sil_r + {6'h00, hb_tick};
      else if (ms_tick && gms_r != gap_r)
         gms_r <= gms_r + 14'h1;

   always_comb
   begin
      fr_end = 1'b0;
      fr_err = 1'b0;
      if (!text)
      begin
         fr_end = in_fr_r && sil_r == `MSP_SIL_HALFBITS && gms_r == gap_r;
         // residue zero when crc is intact
         fr_err = fbad_r || crc_r != 16'h0000;
      end
      else
      begin
         // cr then lf ends the frame
         fr_end = in_fr_r && rx_v && cr_r && rx_byte == `MSP_CH_LF;
         // lrc sum of all bytes is zero
         fr_err = fbad_r || lrc_r != 8'h00 || nib_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         in_fr_r <= 1'b0;
         first_r <= 1'b0;
         nib_r   <= 1'b0;
         cr_r    <= 1'b0;
         fbad_r  <= 1'b0;
         hit_r   <= 1'b0;
         crc_r   <= `MSP_CRC_INIT;
         lrc_r   <= '0;
         hi_r    <= '0;
      end
      else if (fr_end)
         in_fr_r <= 1'b0;
      else if (rx_v && !text)
      begin
         in_fr_r <= 1'b1;
         fbad_r  <= (in_fr_r && fbad_r) || rx_bad;
         crc_r   <= crc_step(in_fr_r ? crc_r : `MSP_CRC_INIT, rx_byte);
         if (!in_fr_r)
            hit_r <= addr_hit(rx_byte, addr_r);
      end
      else if (rx_v && rx_byte == `MSP_CH_COLON)
      begin
         in_fr_r <= 1'b1;
         first_r <= 1'b1;
         nib_r   <= 1'b0;
         cr_r    <= 1'b0;
         fbad_r  <= rx_bad;
         hit_r   <= 1'b0;
         lrc_r   <= '0;
      end
      else if (rx_v && in_fr_r)
      begin
         cr_r <= rx_byte == `MSP_CH_CR;
         if (rx_bad || (!hv[4] && rx_byte != `MSP_CH_CR))
            fbad_r <= 1'b1;
         if (hv[4])
         begin
            nib_r <= !nib_r;
            hi_r  <= hv[3:0];
            if (nib_r)
            begin
               lrc_r   <= lrc_r + hbyte;
               first_r <= 1'b0;
               if (first_r)
                  hit_r <= addr_hit(hbyte, addr_r);
            end
         end
      end

   // ---------------- transmitter
   msp_pkg::msp_tx_e tx_st_r;
   logic [31:0] tx_cnt_r;
   logic [2:0]  tx_bit_r;
   logic [7:0]  tx_buf_r, tx_sh_r;
   logic        tx_full_r, tx_last_r, tx_stop2_r, txd_r, rts_r;
   logic [13:0] hs_ms_r;
   logic        tx_load, tx_drop, tx_tick;
   logic        apb_wr, apb_rd, apb_acc;
   assign tx_tick = tx_cnt_r == '0;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_st_r    <= msp_pkg::TX_IDLE;
         tx_cnt_r   <= '0;
         tx_bit_r   <= '0;
         tx_sh_r    <= '0;
         tx_stop2_r <= 1'b0;
         txd_r      <= 1'b1;
         rts_r      <= 1'b0;
         hs_ms_r    <= '0;
      end
      else
      begin
         tx_cnt_r <= tx_tick ? div - 32'h1 : tx_cnt_r - 32'h1;
         unique case (tx_st_r)
            msp_pkg::TX_IDLE:
            begin
               if (!modem)
                  rts_r <= 1'b0;
               hs_ms_r <= '0;
               if (tx_full_r)
               begin
                  if (modem && !rts_r)
                  begin
                     rts_r   <= 1'b1;
                     tx_st_r <= msp_pkg::TX_RTS;
                  end
                  else if (!flow || cts_s_r)
                     tx_st_r <= msp_pkg::TX_START;
               end
            end
            msp_pkg::TX_RTS:
               if (cts_s_r)
                  tx_st_r <= msp_pkg::TX_START;
               else if (hs_ms_r >= 14'(hsd_r * `MSP_HSD_STEP_MS))
               begin
                  rts_r   <= 1'b0;
                  tx_st_r <= msp_pkg::TX_IDLE;
               end
               else if (ms_tick)
                  hs_ms_r <= hs_ms_r + 14'h1;
            msp_pkg::TX_START:
            begin
               txd_r      <= 1'b0;
               tx_sh_r    <= tx_buf_r;
               tx_bit_r   <= '0;
               tx_stop2_r <= ctrl_r[`MSP_CTRL_STOP2];
               tx_cnt_r   <= div - 32'h1;
               tx_st_r    <= msp_pkg::TX_DATA;
            end
            msp_pkg::TX_DATA:
               if (tx_tick)
               begin
                  txd_r    <= tx_sh_r[0];
                  tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                  tx_bit_r <= tx_bit_r + 3'h1;
                  // stop count starts from zero even without parity
                  if (tx_bit_r == last_bit)
                  begin
                     tx_bit_r <= '0;
                     tx_st_r  <= (par == msp_pkg::PAR_NONE) ?
                                 msp_pkg::TX_STOP : msp_pkg::TX_PAR;
                  end
               end
            msp_pkg::TX_PAR:
               if (tx_tick)
               begin
                  txd_r   <= par_bit(tx_buf_r, text, par);
                  tx_st_r <= msp_pkg::TX_STOP;
                  tx_bit_r <= '0;
               end
            msp_pkg::TX_STOP:
               if (tx_tick)
               begin
                  txd_r    <= 1'b1;
                  tx_bit_r <= tx_bit_r + 3'h1;
                  if (tx_bit_r == {2'b00, tx_stop2_r} + 3'h1)
                  begin
                     tx_st_r <= msp_pkg::TX_IDLE;
                     if (tx_last_r)
                        rts_r <= 1'b0;
                  end
               end
         endcase
      end
   assign tx_load = tx_st_r == msp_pkg::TX_START;
   assign tx_drop = tx_st_r == msp_pkg::TX_RTS && !cts_s_r
                    && hs_ms_r >= 14'(hsd_r * `MSP_HSD_STEP_MS);

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_full_r <= 1'b0;
         tx_buf_r  <= '0;
         tx_last_r <= 1'b0;
      end
      else if (apb_wr && paddr == `MSP_OFF_TXDATA && !tx_full_r)
      begin
         tx_full_r <= 1'b1;
         tx_buf_r  <= pwdata[7:0];
         tx_last_r <= pwdata[`MSP_TX_LAST];
      end
      else if (tx_load || tx_drop)
         tx_full_r <= 1'b0;

   assign txd = txd_r;
   assign drive_en = line_rs485 && tx_st_r != msp_pkg::TX_IDLE
                     && tx_st_r != msp_pkg::TX_RTS;
   // rts guards the receive buffer under flow control
   assign rts = flow ? !st_r[`MSP_ST_RXAV] : (modem && rts_r);

   // ---------------- apb registers
   logic [7:0] rx_buf_r;
   logic       hit_map, rd_pop;
   assign apb_acc = psel && penable;
   assign apb_wr  = apb_acc && pwrite;
   assign apb_rd  = apb_acc && !pwrite;
   assign rd_pop  = apb_rd && paddr == `MSP_OFF_RXDATA;
   assign hit_map = paddr == `MSP_OFF_CTRL || paddr == `MSP_OFF_GAP
                    || paddr == `MSP_OFF_HSDLY || paddr == `MSP_OFF_ADDR
                    || paddr == `MSP_OFF_STATUS || paddr == `MSP_OFF_TXDATA
                    || paddr == `MSP_OFF_RXDATA;
   assign pready  = 1'b1;
   assign pslverr = apb_acc && !hit_map;
   assign prdata  = rd_r;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctrl_r <= `MSP_CTRL_RST;
         gap_r  <= `MSP_GAP_RST;
         hsd_r  <= `MSP_HSD_RST;
         addr_r <= `MSP_ADDR_RST;
      end
      else if (apb_wr)
         unique case (paddr)
            `MSP_OFF_CTRL:
               ctrl_r <= pwdata[8:0];
            `MSP_OFF_GAP:
               gap_r <= (pwdata[13:0] > `MSP_GAP_MAX) ? `MSP_GAP_MAX
                        : pwdata[13:0];
            `MSP_OFF_HSDLY:
               hsd_r <= (pwdata[6:0] > `MSP_HSD_MAX) ? `MSP_HSD_MAX
                        : pwdata[6:0];
            `MSP_OFF_ADDR:
               addr_r <= pwdata[7:0];
            default:
               ctrl_r <= ctrl_r;
         endcase

   // sticky status: hardware set wins over write-one clear, rxav set over an rxdata read; txbusy and txfull are live copies, not sticky
   logic [8:0] w1c;
   assign w1c = (apb_wr && paddr == `MSP_OFF_STATUS) ? pwdata[8:0] : '0;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         st_r     <= '0;
         rx_buf_r <= '0;
      end
      else
      begin
         if (rx_v)
            rx_buf_r <= rx_byte;
         st_r[`MSP_ST_RXAV] <= rx_v || (st_r[`MSP_ST_RXAV] && !rd_pop);
         st_r[`MSP_ST_OVR]  <= (rx_v && st_r[`MSP_ST_RXAV] && !rd_pop)
                               || (st_r[`MSP_ST_OVR] && !w1c[`MSP_ST_OVR]);
         st_r[`MSP_ST_DONE] <= fr_end
                               || (st_r[`MSP_ST_DONE] && !w1c[`MSP_ST_DONE]);
         st_r[`MSP_ST_CHKERR] <= (fr_end && fr_err) || (st_r[`MSP_ST_CHKERR]
                                 && !w1c[`MSP_ST_CHKERR]);
         st_r[`MSP_ST_CHARERR] <= (rx_v && rx_bad) || (st_r[`MSP_ST_CHARERR]
                                  && !w1c[`MSP_ST_CHARERR]);
         st_r[`MSP_ST_HIT]  <= (fr_end && hit_r)
                               || (st_r[`MSP_ST_HIT] && !w1c[`MSP_ST_HIT]);
         st_r[`MSP_ST_TXBUSY] <= tx_st_r != msp_pkg::TX_IDLE;
         st_r[`MSP_ST_DROP] <= tx_drop
                               || (st_r[`MSP_ST_DROP] && !w1c[`MSP_ST_DROP]);
         st_r[`MSP_ST_TXFULL] <= tx_full_r;
      end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rd_r <= '0;
      else if (psel && !penable && !pwrite)
         unique case (paddr)
            `MSP_OFF_CTRL:   rd_r <= {23'h0, ctrl_r};
            `MSP_OFF_GAP:    rd_r <= {18'h0, gap_r};
            `MSP_OFF_HSDLY:  rd_r <= {25'h0, hsd_r};
            `MSP_OFF_ADDR:   rd_r <= {24'h0, addr_r};
            `MSP_OFF_STATUS: rd_r <= {23'h0, st_r};
            `MSP_OFF_RXDATA: rd_r <= {24'h0, rx_buf_r};
            default:         rd_r <= '0;
         endcase
endmodule

// ==== design/msp_map.svh ====
// register map, field positions, reset values and timing figures
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH
`define MSP_OFF_CTRL      8'h00
`define MSP_OFF_GAP       8'h04
`define MSP_OFF_HSDLY     8'h08
`define MSP_OFF_ADDR      8'h0c
`define MSP_OFF_STATUS    8'h10
`define MSP_OFF_TXDATA    8'h14
`define MSP_OFF_RXDATA    8'h18
`define MSP_CTRL_BAUD     2:0
`define MSP_CTRL_TEXT     3
`define MSP_CTRL_STOP2    4
`define MSP_CTRL_PAR      6:5
`define MSP_CTRL_RS485    7
`define MSP_CTRL_HS       8
`define MSP_CTRL_RST      9'h005
`define MSP_GAP_RST       14'h0002
`define MSP_GAP_MAX       14'h2710
`define MSP_HSD_RST       7'h00
`define MSP_HSD_MAX       7'h64
`define MSP_HSD_STEP_MS   14'h0064
`define MSP_ADDR_RST      8'h01
`define MSP_ADDR_BCAST    8'h00
`define MSP_ADDR_P2P      8'hf8
`define MSP_ST_RXAV       0
`define MSP_ST_OVR        1
`define MSP_ST_DONE       2
`define MSP_ST_CHKERR     3
`define MSP_ST_CHARERR    4
`define MSP_ST_HIT        5
`define MSP_ST_TXBUSY     6
`define MSP_ST_DROP       7
`define MSP_ST_TXFULL     8
`define MSP_TX_LAST       8
`define MSP_CLK_HZ        200000000
`define MSP_MS_PER_S      1000
`define MSP_SIL_HALFBITS  7'h4d
`define MSP_CRC_INIT      16'hffff
`define MSP_CRC_POLY      16'ha001
`define MSP_CH_COLON      8'h3a
`define MSP_CH_CR         8'h0d
`define MSP_CH_LF         8'h0a
`define MSP_BITS_TEXT     3'h6
`define MSP_BITS_BIN      3'h7
`endif

// ==== design/msp_pkg.sv ====
// types shared by the serial port design
package msp_pkg;
   typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE, PAR_RSVD} msp_par_e;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} msp_rx_e;
   typedef enum {TX_IDLE, TX_RTS, TX_START, TX_DATA, TX_PAR, TX_STOP}
      msp_tx_e;
   typedef enum {BAUD_300, BAUD_600, BAUD_1200, BAUD_2400, BAUD_4800,
                 BAUD_9600, BAUD_19200} msp_baud_e;
endpackage

// ==== bench/msp_uart_chk.sv ====
// checker on the serial port pins and apb strobes
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_uart_chk (
   // clock, reset, apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   // line
   input wire logic        txd,
   input wire logic        rts,
   input wire logic        line_rs485,
   input wire logic        drive_en
);
   logic [8:0] ctl_r;
   logic       hsd_r;
   // mirror of the mode fields
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctl_r <= `MSP_CTRL_RST;
         hsd_r <= 1'b0;
      end
      else if (psel && penable && pwrite)
      begin
         if (paddr == `MSP_OFF_CTRL)
            ctl_r <= pwdata[8:0];
         if (paddr == `MSP_OFF_HSDLY)
            hsd_r <= |pwdata[6:0];
      end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_err;
      pslverr == (psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'b00));
   endproperty
   a_err: assert property (p_err) else $error("slave error mismatch");
   property p_sel; line_rs485 == ctl_r[7]; endproperty
   a_sel: assert property (p_sel) else $error("line mode wrong");
   property p_de; drive_en |-> line_rs485; endproperty
   a_de: assert property (p_de) else $error("driver on in rs232");
   property p_drv; line_rs485 && !txd |-> drive_en; endproperty
   a_drv: assert property (p_drv) else $error("driver off in rs485");
   property p_plain; !ctl_r[8] && !$past(ctl_r[8]) |-> !rts; endproperty
   a_plain: assert property (p_plain) else $error("rts without hs");
   property p_nohs; line_rs485 |-> !rts; endproperty
   a_nohs: assert property (p_nohs) else $error("rts in rs485");
   property p_lo; $fell(txd) |-> !txd [*4]; endproperty
   a_lo: assert property (p_lo) else $error("short low cell");
   property p_hi; $rose(txd) |-> txd [*4]; endproperty
   a_hi: assert property (p_hi) else $error("short high cell");
   property p_mdm;
      ctl_r[8] && hsd_r && !line_rs485 && $fell(txd) |-> rts;
   endproperty
   a_mdm: assert property (p_mdm) else $error("sent without rts");
endmodule

// ==== bench/msp_peer.sv ====
// serial master model facing the port's line pins
`timescale 1ns/100ps
module msp_peer (
   // line pins
   input  wire logic pclk,
   input  wire logic txd,
   output logic      rxd,
   output logic      cts
);
   int         bitc = 10;
   int         ncap = 0;
   logic [9:0] cap_r;
   logic       req_r = 1'b0;
   assign cts = req_r;
   initial rxd = 1'b1;
   task automatic send(input logic [10:0] f);
      for (int i = 0; i < 11; i++)
      begin
         rxd <= f[i];
         repeat (bitc) @(posedge pclk);
      end
   endtask
   // cells after start, sampled mid-cell
   always
   begin
      @(negedge txd);
      repeat (bitc / 2) @(posedge pclk);
      for (int i = 0; i < 10; i++)
      begin
         repeat (bitc) @(posedge pclk);
         cap_r[i] = txd;
      end
      ncap++;
   end
endmodule

// ==== bench/msp_uart_tb.sv ====
// self-checking bench for the serial slave port
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_uart_tb;
   localparam logic [7:0] ST = `MSP_OFF_STATUS;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        rerr, rxd, txd, cts, rts, line_rs485, drive_en;
   int          fail_count = 0, tests_run = 0, n;
   int          rate [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
   logic [7:0]  q [$];
   msp_uart #(.CLK_HZ(96000), .MS_CYC(50)) u_dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd,
      .txd, .cts, .rts, .line_rs485, .drive_en);
   msp_peer u_peer (.pclk, .txd, .rxd, .cts);
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   function automatic logic [31:0] ex(input logic [8:0] c,
                                      input logic [7:0] b);
      logic p;
      p = (c[6:5] == 2'd2) | ((^(c[3] ? {1'b0, b[6:0]} : b)) ^ c[5]);
      return c[3] ? {22'h0, 2'b11, p, b[6:0]} : {22'h0, 1'b1, p, b};
   endfunction
   function automatic logic [15:0] crc(input logic [7:0] v [$]);
      logic [15:0] c;
      c = `MSP_CRC_INIT;
      foreach (v[i])
      begin
         c ^= {8'h00, v[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ `MSP_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   task automatic ch(input logic [7:0] b, input logic t);
      u_peer.send(t ? {2'b11, ^b[6:0], b[6:0], 1'b0} : {1'b1, ^b, b, 1'b0});
   endtask
   task automatic txt(input string s);
      foreach (s[i]) ch(s[i], 1'b1);
   endtask
   task automatic bin(input logic [7:0] a, input logic [7:0] bad);
      logic [15:0] c;
      q = '{a, 8'h03};
      c = crc(q);
      q.push_back(c[7:0] ^ bad);
      q.push_back(c[15:8]);
      foreach (q[i]) ch(q[i], 1'b0);
      repeat (400) @(posedge pclk);
      rd(ST, 32'h4, 32'h0);
      repeat (300) @(posedge pclk);
   endtask
   task automatic tx(input logic [8:0] c, input logic [8:0] b);
      wr(`MSP_OFF_CTRL, 32'(c));
      u_peer.bitc = 96000 / rate[c[2:0]];
      n = u_peer.ncap;
      wr(`MSP_OFF_TXDATA, 32'(b));
      wait (u_peer.ncap != n);
      chk(32'(u_peer.cap_r), ex(c, b[7:0]));
      repeat (u_peer.bitc) @(posedge pclk);
      if (c[6:5] != 2'h2 && !c[3])
         rd(ST, 32'h40, {25'h0, c[4], 6'h0});
      repeat (u_peer.bitc) @(posedge pclk);
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`MSP_OFF_CTRL, '1, 32'h5);
      rd(`MSP_OFF_ADDR, '1, 32'h1);
      rd(`MSP_OFF_HSDLY, '1, 32'h0);
      rd(`MSP_OFF_GAP, '1, 32'd2);
      wr(`MSP_OFF_GAP, 32'd10001);
      rd(`MSP_OFF_GAP, '1, 32'd10000);
      wr(`MSP_OFF_GAP, 32'd2);
      wr(`MSP_OFF_HSDLY, 32'd101);
      rd(`MSP_OFF_HSDLY, '1, 32'd100);
      wr(`MSP_OFF_HSDLY, 32'd0);
      rd(8'h40, '1, 32'h0);
      chk(32'(rerr), 32'h1);
      $display("test registers done");
      for (int r = 0; r < 7; r++) tx(9'(r), 9'(8'ha5 ^ 8'(r)));
      tx(9'h025, 9'h03c);
      tx(9'h045, 9'h081);
      tx(9'h015, 9'h0f0);
      tx(9'h00d, 9'h05a);
      $display("test transmit done");
      txt("A:0103FC\r");
      rd(ST, 32'h4, 32'h0);
      ch(8'h0a, 1'b1);
      repeat (30) @(posedge pclk);
      rd(ST, 32'h2c, 32'h24);
      wr(ST, 32'hbe);
      txt(":0103FD\r\n");
      repeat (30) @(posedge pclk);
      rd(ST, 32'h0c, 32'h0c);
      wr(ST, 32'hbe);
      wr(`MSP_OFF_CTRL, 32'h5);
      bin(8'h01, 8'h00);
      rd(ST, 32'h2c, 32'h24);
      wr(ST, 32'hbe);
      bin(8'h05, 8'h01);
      rd(ST, 32'h2c, 32'h0c);
      wr(ST, 32'hbe);
      wr(`MSP_OFF_ADDR, 32'd248);
      bin(8'h05, 8'h00);
      rd(ST, 32'h2c, 32'h24);
      $display("test receive done");
      wr(`MSP_OFF_CTRL, 32'h105);
      wr(`MSP_OFF_HSDLY, 32'd1);
      n = u_peer.ncap;
      wr(`MSP_OFF_TXDATA, 32'h1a5);
      repeat (20) @(posedge pclk);
      chk(32'(rts), 32'h1);
      repeat (4880) @(posedge pclk);
      rd(ST, 32'h80, 32'h0);
      repeat (300) @(posedge pclk);
      rd(ST, 32'h80, 32'h80);
      chk(u_peer.ncap, n);
      wr(ST, 32'hbe);
      wr(`MSP_OFF_TXDATA, 32'h15a);
      repeat (20) @(posedge pclk);
      u_peer.req_r <= 1'b1;
      wait (u_peer.ncap != n);
      chk(32'(u_peer.cap_r), ex(9'h005, 8'h5a));
      repeat (20) @(posedge pclk);
      chk(32'(rts), 32'h0);
      wr(`MSP_OFF_HSDLY, 32'd0);
      u_peer.req_r <= 1'b0;
      apb(1'b0, `MSP_OFF_RXDATA, 32'h0);
      @(posedge pclk);
      chk(32'(rts), 32'h1);
      wr(`MSP_OFF_TXDATA, 32'h133);
      repeat (300) @(posedge pclk);
      chk(u_peer.ncap, n + 1);
      u_peer.req_r <= 1'b1;
      wait (u_peer.ncap != n + 1);
      chk(32'(u_peer.cap_r), ex(9'h005, 8'h33));
      ch(8'h11, 1'b0);
      repeat (20) @(posedge pclk);
      chk(32'(rts), 32'h0);
      wr(`MSP_OFF_HSDLY, 32'd1);
      u_peer.req_r <= 1'b0;
      wr(`MSP_OFF_CTRL, 32'h185);
      @(posedge pclk);
      chk(32'(line_rs485), 32'h1);
      chk(32'(rts), 32'h0);
      tx(9'h185, 9'h1c3);
      $display("test handshake done");
      test_done;
   end
   initial
   begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      test_done;
   end
endmodule
bind msp_uart msp_uart_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pslverr, .txd, .rts, .line_rs485, .drive_en);
